// >>> ptu_pkg.sv
// constants, types and field layout shared by the paging unit and its translation memory
// What this block does
// - two table levels map linear to physical
// - directory, tables and frames are 4K each
// - fault captures whole linear address, overwriting
// - directory base low twelve bits read zero
// - base load flushes every cached translation
// - bits 31..22 index directory entry
// - bits 21..12 index table entry
// - frame joined with low twelve linear bits
// - entry used only when present bit set
// - set accessed bit before covered access
// - set table dirty bit before write
// - flag updates are locked read-modify-write
// - bits 11..9 ignored and never modified
// - bit 2 user, bit 1 write attribute
// - only level 3 checked, others bypass
// - effective attribute is smaller of pair
// - level 3 access table: none, read, both
// - 32 entries, four ways, cached table entries
// - hardware refills buffer, walk on miss or on first write through a clean entry
// - compare upper 20 bits, hit skips walk unless it is a write through a clean entry
// - fault on not present or violation
// - error code gives cause, direction, user
package ptu_pkg;
   localparam int LIN_W = 32;             // linear and physical address width
   localparam int PAGE_BYTES = 4096;      // page, table and directory size
   localparam int PAGE_OFS_W = $clog2(PAGE_BYTES);
   localparam int FRAME_W = LIN_W - PAGE_OFS_W;
   localparam int IDX_W = 10;             // index width of each table level
   localparam int DIR_IDX_LSB = PAGE_OFS_W + IDX_W;
   localparam int ENTRY_SHIFT = 2;        // entries are four bytes
   localparam int ENTRIES = 32;           // cached translations
   localparam int WAYS = 4;
   localparam int SETS = ENTRIES / WAYS;
   localparam int SET_W = $clog2(SETS);
   localparam int WAY_W = $clog2(WAYS);
   localparam int TAG_W = FRAME_W - SET_W;
   // entry flag positions
   localparam int BIT_P = 0;
   localparam int BIT_RW = 1;
   localparam int BIT_US = 2;
   localparam int BIT_A = 5;
   localparam int BIT_D = 6;
   localparam int RSV_LSB = 9;
   localparam int RSV_MSB = 11;
   // error code positions
   localparam int EC_P = 0;
   localparam int EC_WR = 1;
   localparam int EC_US = 2;
   localparam logic [1:0] USER_CPL = 2'h3;
   localparam logic CTL_SEL_FAULT = 1'h0; // register select codes
   localparam logic CTL_SEL_BASE = 1'h1;
   localparam logic [LIN_W-1:0] FAULT_RESET = 32'h0000_0000;
   localparam logic [LIN_W-1:0] BASE_RESET = 32'h0000_0000;
   localparam logic [2:0] PLRU_RESET = 3'h0;

   typedef struct packed {
      logic [LIN_W-1:0] lin; // linear address from segmentation
      logic write;           // 1 for a write access
      logic [1:0] cpl;       // current privilege level
   } ptu_req_s;

   typedef struct packed {
      logic [TAG_W-1:0] tag;
      logic [FRAME_W-1:0] frame;
      logic [1:0] attr;      // effective {user, write} pair
      logic dirty;
   } ptu_way_s;

   typedef enum {
      ST_IDLE, ST_LOOKUP, ST_DIR_RD, ST_TBL_RD, ST_DIR_WR, ST_TBL_WR, ST_FILL
   } ptu_state_e;
endpackage

// >>> ptu_tlb_mem.sv
// translation memory: one small array per way, registered read of a whole set
`timescale 1ns/10ps
`default_nettype none
module ptu_tlb_mem (
   input wire logic i_clk,
   input wire logic [ptu_pkg::SET_W-1:0] i_rd_set,
   output var ptu_pkg::ptu_way_s [ptu_pkg::WAYS-1:0] o_rd_ways,
   input wire logic i_wr_en,
   input wire logic [ptu_pkg::SET_W-1:0] i_wr_set,
   input wire logic [ptu_pkg::WAY_W-1:0] i_wr_way,
   input wire ptu_pkg::ptu_way_s i_wr_data
);
   import ptu_pkg::*;

   // one array per way so a whole set reads in one cycle
   for (genvar g = 0; g < WAYS; g++) begin : g_way
      ptu_way_s mem [SETS];  // no reset: valid bits live outside
      ptu_way_s rd_q;        // registered read word

      // write the chosen way, read the addressed set every cycle
      always_ff @(posedge i_clk) begin
         if (i_wr_en && i_wr_way == WAY_W'(g)) begin
            mem[i_wr_set] <= i_wr_data;
         end
         rd_q <= mem[i_rd_set];
      end
      assign o_rd_ways[g] = rd_q;
   end
endmodule
`default_nettype wire

// >>> ptu_paging.sv
// paging unit: translation buffer lookup, two-level walk, flag updates, protection
`timescale 1ns/10ps
`default_nettype none
module ptu_paging (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_req_valid,
   input wire ptu_pkg::ptu_req_s i_req,
   output logic o_req_ready,
   output logic o_rsp_valid,
   output logic o_rsp_fault,
   output logic [ptu_pkg::LIN_W-1:0] o_rsp_phys,
   output logic [2:0] o_rsp_code,
   output logic o_mem_req,
   output logic o_mem_we,
   output logic o_mem_lock,
   output logic [ptu_pkg::LIN_W-1:0] o_mem_addr,
   output logic [ptu_pkg::LIN_W-1:0] o_mem_wdata,
   input wire logic i_mem_ack,
   input wire logic [ptu_pkg::LIN_W-1:0] i_mem_rdata,
   input wire logic i_ctl_wr,
   input wire logic i_ctl_sel,
   input wire logic [ptu_pkg::LIN_W-1:0] i_ctl_wdata,
   input wire logic i_task_base_load,
   input wire logic [ptu_pkg::LIN_W-1:0] i_task_base,
   output logic [ptu_pkg::LIN_W-1:0] o_fault_linear_address,
   output logic [ptu_pkg::LIN_W-1:0] o_directory_base
);
   import ptu_pkg::*;

   // page access check for one attribute pair
   function automatic logic allowed(input logic [1:0] attr, input logic user, input logic wr);
      allowed = !user || (attr[1] && (!wr || attr[0]));
   endfunction

   // more restrictive pair is the numerically smaller one
   function automatic logic [1:0] min_attr(input logic [1:0] a, input logic [1:0] b);
      min_attr = (a < b) ? a : b;
   endfunction

   // tree pseudo-lru: bit2 picks pair, bit0/bit1 pick way in pair
   function automatic logic [WAY_W-1:0] plru_victim(input logic [2:0] t);
      plru_victim = t[2] ? {1'b1, t[1]} : {1'b0, t[0]};
   endfunction

   // point the tree away from the way just used; the other pair's bit is kept
   function automatic logic [2:0] plru_touch(input logic [2:0] t, input logic [WAY_W-1:0] w);
      plru_touch = w[1] ? {1'b0, ~w[0], t[0]} : {1'b1, t[1], ~w[0]};
   endfunction

   ptu_state_e state, next_state; // walk sequencer
   ptu_req_s req_q;                    // request under service
   logic [LIN_W-1:0] pde_q, pte_q; // directory and table entries read
   logic [1:0] eff_q;                  // effective attribute pair
   logic [WAY_W-1:0] victim_q;         // way to refill
   logic [SETS-1:0][WAYS-1:0] valid;   // per-entry valid bits
   logic [SETS-1:0][2:0] plru;         // per-set replacement tree
   logic flushed;                      // flush seen during this request
   logic issued;                       // bus cycle of this state is out
   ptu_way_s [WAYS-1:0] rd_ways;       // set read from memory
   ptu_way_s fill_way;                 // entry written on refill
   logic [SET_W-1:0] rd_set, set_q; // set read now, set of the request
   logic [TAG_W-1:0] tag_q; // tag of the request
   logic user;                         // access made at level 3
   logic accept, ack, flush; // request taken, bus cycle done, translations dropped
   logic hit, finish, do_fault, fault_prot, touch, fill; // sequencer decisions
   logic [WAY_W-1:0] hit_way, victim; // matching way, way to replace
   logic [LIN_W-1:0] phys_now, mem_addr_now, wdata_now; // next answer and bus values

   assign accept = i_req_valid && o_req_ready;
   assign ack = i_mem_ack && o_mem_req;
   assign flush = (i_ctl_wr && i_ctl_sel == CTL_SEL_BASE) || i_task_base_load;
   assign set_q = req_q.lin[PAGE_OFS_W +: SET_W];
   assign tag_q = req_q.lin[LIN_W-1 -: TAG_W];
   assign user = (req_q.cpl == USER_CPL);
   // read the new set while idle so the lookup sees it next cycle
   assign rd_set = (state == ST_IDLE) ? i_req.lin[PAGE_OFS_W +: SET_W] : set_q;

   ptu_tlb_mem u_mem (
      .i_clk(i_clk),
      .i_rd_set(rd_set),
      .o_rd_ways(rd_ways),
      .i_wr_en(fill && !flushed && !flush),
      .i_wr_set(set_q),
      .i_wr_way(victim_q),
      .i_wr_data(fill_way)
   );

   // refill word: cached table entry with effective rights; frames are whole pages
   assign fill_way = '{tag_q, pte_q[LIN_W-1:PAGE_OFS_W], eff_q, pte_q[BIT_D] || req_q.write};

   // compare the upper address bits against every way of the set
   always_comb begin
      hit = 1'b0;
      hit_way = '0;
      victim = plru_victim(plru[set_q]);
      for (int w = 0; w < WAYS; w++) begin
         if (valid[set_q][w] && rd_ways[w].tag == tag_q) begin
            hit = 1'b1;
            hit_way = WAY_W'(w);
         end
      end
      // an empty way is always taken before evicting
      for (int w = WAYS - 1; w >= 0; w--) begin
         if (!valid[set_q][w]) begin
            victim = WAY_W'(w);
         end
      end
   end

   // bus address and write data for the current walk step
   always_comb begin
      mem_addr_now = {o_directory_base[LIN_W-1:PAGE_OFS_W],
                      req_q.lin[LIN_W-1:DIR_IDX_LSB], ENTRY_SHIFT'(0)};
      wdata_now = pde_q;
      wdata_now[BIT_A] = 1'b1;
      if (state == ST_TBL_RD || state == ST_TBL_WR) begin
         mem_addr_now = {pde_q[LIN_W-1:PAGE_OFS_W],
                         req_q.lin[DIR_IDX_LSB-1:PAGE_OFS_W], ENTRY_SHIFT'(0)};
         // read value is written back with only flag bits ored in
         wdata_now = pte_q;
         wdata_now[BIT_A] = 1'b1;
         wdata_now[BIT_D] = pte_q[BIT_D] || req_q.write;
      end
   end

   // sequencer decisions: hit, walk steps, faults
   always_comb begin
      next_state = state;
      finish = 1'b0;
      do_fault = 1'b0;
      fault_prot = 1'b0;
      touch = 1'b0;
      fill = 1'b0;
      phys_now = {pte_q[LIN_W-1:PAGE_OFS_W], req_q.lin[PAGE_OFS_W-1:0]};
      case (state)
         ST_IDLE: begin
            if (accept) begin
               next_state = ST_LOOKUP;
            end
         end
         ST_LOOKUP: begin
            phys_now = {rd_ways[hit_way].frame, req_q.lin[PAGE_OFS_W-1:0]};
            if (!hit) begin
               next_state = ST_DIR_RD;
            end else if (!allowed(rd_ways[hit_way].attr, user, req_q.write)) begin
               finish = 1'b1;
               do_fault = 1'b1;
               fault_prot = 1'b1;
            end else if (req_q.write && !rd_ways[hit_way].dirty) begin
               // first write through a clean entry must still mark memory dirty
               next_state = ST_DIR_RD;
            end else begin
               finish = 1'b1;
               touch = 1'b1;
            end
         end
         ST_DIR_RD: begin
            if (ack) begin
               if (!i_mem_rdata[BIT_P]) begin
                  finish = 1'b1;
                  do_fault = 1'b1;
               end else begin
                  next_state = ST_TBL_RD;
               end
            end
         end
         ST_TBL_RD: begin
            if (ack) begin
               if (!i_mem_rdata[BIT_P]) begin
                  finish = 1'b1;
                  do_fault = 1'b1;
               end else if (!allowed(min_attr(pde_q[BIT_US:BIT_RW], i_mem_rdata[BIT_US:BIT_RW]),
                                     user, req_q.write)) begin
                  finish = 1'b1;
                  do_fault = 1'b1;
                  fault_prot = 1'b1;
               end else if (!pde_q[BIT_A]) begin
                  next_state = ST_DIR_WR;
               end else if (!i_mem_rdata[BIT_A] || (req_q.write && !i_mem_rdata[BIT_D])) begin
                  next_state = ST_TBL_WR;
               end else begin
                  next_state = ST_FILL;
               end
            end
         end
         ST_DIR_WR: begin
            if (ack) begin
               if (!pte_q[BIT_A] || (req_q.write && !pte_q[BIT_D])) begin
                  next_state = ST_TBL_WR;
               end else begin
                  next_state = ST_FILL;
               end
            end
         end
         ST_TBL_WR: begin
            if (ack) begin
               next_state = ST_FILL;
            end
         end
         ST_FILL: begin
            finish = 1'b1;
            fill = 1'b1;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      if (finish) begin
         next_state = ST_IDLE;
      end
   end

   // sequencer state, captured entries and the answer to the segmentation unit
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state <= ST_IDLE;
         req_q <= '0;
         pde_q <= '0;
         pte_q <= '0;
         eff_q <= '0;
         victim_q <= '0;
         o_req_ready <= 1'b1;
         o_rsp_valid <= 1'b0;
         o_rsp_fault <= 1'b0;
         o_rsp_phys <= '0;
         o_rsp_code <= '0;
      end else begin
         state <= next_state;
         o_rsp_valid <= finish;
         if (accept) begin
            req_q <= i_req;
            o_req_ready <= 1'b0;
         end
         if (state == ST_LOOKUP) begin
            victim_q <= hit ? hit_way : victim;
         end
         if (state == ST_DIR_RD && ack) begin
            pde_q <= i_mem_rdata;
         end
         if (state == ST_TBL_RD && ack) begin
            pte_q <= i_mem_rdata;
            eff_q <= min_attr(pde_q[BIT_US:BIT_RW], i_mem_rdata[BIT_US:BIT_RW]);
         end
         if (finish) begin
            o_req_ready <= 1'b1;
            o_rsp_fault <= do_fault;
            o_rsp_phys <= do_fault ? '0 : phys_now;
            o_rsp_code[EC_P] <= fault_prot;
            o_rsp_code[EC_WR] <= req_q.write;
            o_rsp_code[EC_US] <= user;
         end
      end
   end

   // bus master: one cycle per walk step, lock held from first read to the end
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_mem_req <= 1'b0;
         o_mem_we <= 1'b0;
         o_mem_lock <= 1'b0;
         o_mem_addr <= '0;
         o_mem_wdata <= '0;
         issued <= 1'b0;
      end else begin
         if (ack) begin
            o_mem_req <= 1'b0;
            issued <= 1'b0;
         end else if (!issued && (state == ST_DIR_RD || state == ST_TBL_RD ||
                                  state == ST_DIR_WR || state == ST_TBL_WR)) begin
            o_mem_req <= 1'b1;
            o_mem_lock <= 1'b1;
            o_mem_we <= (state == ST_DIR_WR || state == ST_TBL_WR);
            o_mem_addr <= mem_addr_now;
            o_mem_wdata <= wdata_now;
            issued <= 1'b1;
         end
         // lock drops only when the whole walk is over
         if (finish) begin
            o_mem_lock <= 1'b0;
         end
      end
   end

   // fault address and directory base registers
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_fault_linear_address <= FAULT_RESET;
         o_directory_base <= BASE_RESET;
      end else begin
         // a fault wins over a software write in the same cycle
         if (finish && do_fault) begin
            o_fault_linear_address <= req_q.lin;
         end else if (i_ctl_wr && i_ctl_sel == CTL_SEL_FAULT) begin
            o_fault_linear_address <= i_ctl_wdata;
         end
         // task load and software write never meet; task load checked first
         if (i_task_base_load) begin
            o_directory_base <= {i_task_base[LIN_W-1:PAGE_OFS_W], PAGE_OFS_W'(0)};
         end else if (i_ctl_wr && i_ctl_sel == CTL_SEL_BASE) begin
            o_directory_base <= {i_ctl_wdata[LIN_W-1:PAGE_OFS_W], PAGE_OFS_W'(0)};
         end
      end
   end

   // valid bits and replacement trees; a flush clears all 32 entries at once
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         valid <= '0;
         plru <= {SETS{PLRU_RESET}};
         flushed <= 1'b0;
      end else begin
         if (flush) begin
            valid <= '0;
            flushed <= 1'b1;
         end else if (accept) begin
            flushed <= 1'b0;
         end else if (fill && !flushed) begin
            valid[set_q][victim_q] <= 1'b1;
         end
         if (touch || fill) begin
            plru[set_q] <= plru_touch(plru[set_q], touch ? hit_way : victim_q);
         end
      end
   end

   // checks kept next to the logic
   sequence dir_absent_s;
      state == ST_DIR_RD && ack && !i_mem_rdata[BIT_P];
   endsequence
   sequence fault_absent_s;
      o_rsp_valid && o_rsp_fault && !o_rsp_code[EC_P];
   endsequence

   phys_offset_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      o_rsp_valid && !o_rsp_fault |-> o_rsp_phys[PAGE_OFS_W-1:0] == req_q.lin[PAGE_OFS_W-1:0])
      else $error("physical offset differs from linear offset");
   fault_addr_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      o_rsp_valid && o_rsp_fault |-> o_fault_linear_address == req_q.lin)
      else $error("fault address not captured");
   base_align_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      o_directory_base[PAGE_OFS_W-1:0] == '0)
      else $error("directory base not page aligned");
   base_flush_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      flush |=> valid == '0)
      else $error("base load did not flush buffer");
   dir_index_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      o_mem_req && state == ST_DIR_RD |-> o_mem_addr[PAGE_OFS_W-1:0] == {req_q.lin[LIN_W-1:DIR_IDX_LSB], 2'h0}
         && (flushed || o_mem_addr[LIN_W-1:PAGE_OFS_W] == o_directory_base[LIN_W-1:PAGE_OFS_W]))
      else $error("directory entry address wrong");
   tbl_index_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      o_mem_req && state == ST_TBL_RD |-> o_mem_addr == {pde_q[LIN_W-1:PAGE_OFS_W],
         req_q.lin[DIR_IDX_LSB-1:PAGE_OFS_W], 2'h0})
      else $error("table entry address wrong");
   locked_write_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      o_mem_req && o_mem_we |-> o_mem_lock && $past(o_mem_lock))
      else $error("flag update not inside a locked cycle");
   keep_reserved_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      o_mem_req && o_mem_we && state == ST_TBL_WR |-> o_mem_wdata[LIN_W-1:BIT_D+1] == pte_q[LIN_W-1:BIT_D+1]
         && o_mem_wdata[RSV_MSB:RSV_LSB] == pte_q[RSV_MSB:RSV_LSB]
         && o_mem_wdata[BIT_A-1:0] == pte_q[BIT_A-1:0] && o_mem_wdata[BIT_A])
      else $error("reserved bits changed or accessed bit clear");
   dirty_write_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      o_mem_req && o_mem_we && state == ST_TBL_WR && req_q.write |-> o_mem_wdata[BIT_D])
      else $error("dirty bit not set for write");
   absent_fault_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      dir_absent_s |=> fault_absent_s)
      else $error("absent directory entry did not fault");
endmodule
`default_nettype wire

// >>> ptu_mem_model.sv
// memory partner: entry store that answers walk cycles after a random wait
`timescale 1ns/10ps
`default_nettype none
module ptu_mem_model (
   input wire logic i_clk,
   input wire logic i_req,
   input wire logic i_we,
   input wire logic [31:0] i_addr,
   input wire logic [31:0] i_wdata,
   output logic o_ack,
   output logic [31:0] o_rdata
);
   logic [31:0] m [logic [31:0]]; // sparse store, bench fills it
   int wait_n = -1; // idle cycles left before the ack
   initial begin
      o_ack = 0;
      o_rdata = 0;
   end
   // one-cycle ack; read data toggles outside the ack so stale data is never trusted
   always @(posedge i_clk) begin
      #1 o_rdata = ~o_rdata;
      if (o_ack) begin
         o_ack = 0;
      end else if (i_req) begin
         if (wait_n < 0) wait_n = $urandom % 3;
         if (wait_n == 0) begin
            o_ack = 1;
            if (i_we) m[i_addr] = i_wdata;
            else o_rdata = m.exists(i_addr) ? m[i_addr] : 0;
         end
         wait_n--;
      end
   end
endmodule
`default_nettype wire

// >>> tb_top.sv
// bench: random two-level walks against a reference model, flush and register checks
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import ptu_pkg::*;
   logic clk = 0, rst_n = 0, req_valid = 0, ctl_wr = 0, ctl_sel = 0, tload = 0;
   ptu_req_s req = '0;
   logic [31:0] ctl_wdata = 0, task_base = 0, phys, fla, dbase, maddr, mwdata, mrdata;
   logic ready, rsp_valid, rsp_fault, mreq, mwe, mlock, mack;
   logic [2:0] code;
   int fails = 0, check_count = 0, bus_n = 0;
   always #5 clk = ~clk;
   ptu_paging dut (.i_clk(clk), .i_reset_n(rst_n), .i_req_valid(req_valid), .i_req(req), .o_req_ready(ready),
      .o_rsp_valid(rsp_valid), .o_rsp_fault(rsp_fault), .o_rsp_phys(phys), .o_rsp_code(code), .o_mem_req(mreq),
      .o_mem_we(mwe), .o_mem_lock(mlock), .o_mem_addr(maddr), .o_mem_wdata(mwdata), .i_mem_ack(mack),
      .i_mem_rdata(mrdata), .i_ctl_wr(ctl_wr), .i_ctl_sel(ctl_sel), .i_ctl_wdata(ctl_wdata),
      .i_task_base_load(tload), .i_task_base(task_base), .o_fault_linear_address(fla), .o_directory_base(dbase));
   ptu_mem_model mem (.i_clk(clk), .i_req(mreq), .i_we(mwe), .i_addr(maddr), .i_wdata(mwdata), .o_ack(mack),
      .o_rdata(mrdata));
   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // register write strobe, value visible one cycle later
   task automatic ctl(logic sel, logic [31:0] d);
      @(posedge clk) #1;
      ctl_wr = 1;
      ctl_sel = sel;
      ctl_wdata = d;
      @(posedge clk) #1;
      ctl_wr = 0;
   endtask
   // one translation; the answer is waited for under a bound
   task automatic xlate(logic [31:0] lin, logic wr, logic [1:0] cpl, logic ef, logic [2:0] ec, logic [31:0] ep);
      @(posedge clk) #1;
      req_valid = 1;
      req = '{lin, wr, cpl};
      @(posedge clk) #1;
      req_valid = 0;
      for (int n = 0; n < 100 && rsp_valid !== 1'b1; n++) @(posedge clk) #1;
      check("rsp_valid", {31'h0, rsp_valid}, 32'h1);
      check("fault", {31'h0, rsp_fault}, {31'h0, ef});
      check("code", {29'h0, code}, {29'h0, ec});
      check("phys", phys, ep);
      @(posedge clk) #1;
      if (ef) check("fault_addr", fla, lin);
   endtask
   // every flag update and walk read must run under the bus lock
   // looked at mid-cycle on the ack, when lock and request are both settled
   always @(negedge clk) begin
      if (mack && mreq) begin
         bus_n++;
         check("lock", {31'h0, mlock}, 32'h1);
      end
   end
   initial begin
      #500000;
      fails++;
      test_done();
   end
   initial begin
      logic [31:0] base, lin, pde, pte, pa, ta, lin0, ph0, ta0, d;
      logic wr, np, f;
      logic [1:0] cpl, eff;
      int n0;
      base = 32'h0001_0000;
      void'($urandom(96944));
      repeat (20) @(posedge clk);
      #1 rst_n = 1;
      check("ready", {31'h0, ready}, 32'h1);
      check("base_rst", dbase, 0);
      ctl(1, base | 32'h0000_0abc);
      check("base", dbase, base);
      d = $urandom;
      ctl(0, d);
      check("fault_reg", fla, d);
      // fresh directory slot each pass, so the first access always walks
      for (int i = 0; i < 16; i++) begin
         lin = {i[9:0] + 10'h1, 22'($urandom)};
         pde = {20'h00100 + i[19:0], 3'($urandom), 6'h0, 2'($urandom), i == 0 || $urandom % 4 != 0};
         pte = {20'($urandom), 3'($urandom), 6'h0, 2'($urandom), i == 0 || $urandom % 4 != 0};
         pa = base + {lin[31:22], 2'h0};
         ta = {pde[31:12], lin[21:12], 2'h0};
         mem.m[pa] = pde;
         mem.m[ta] = pte;
         wr = 1'($urandom);
         cpl = i == 0 ? 2'h0 : 2'($urandom);
         np = !pde[0] || !pte[0];
         eff = pde[2:1] < pte[2:1] ? pde[2:1] : pte[2:1];
         f = np || (cpl == 3 && (!eff[1] || (wr && !eff[0])));
         xlate(lin, wr, cpl, f, {cpl == 3, wr, f && !np}, f ? 0 : {pte[31:12], lin[11:0]});
         n0 = bus_n;
         xlate(lin, wr, cpl, f, {cpl == 3, wr, f && !np}, f ? 0 : {pte[31:12], lin[11:0]});
         if (!f) check("hit_bus", bus_n, n0);
         check("dir_entry", mem.m[pa], f ? pde : pde | 32'h20);
         check("tbl_entry", mem.m[ta], f ? pte : pte | 32'h20 | {wr, 6'h0});
         if (i == 0) begin
            lin0 = lin;
            ph0 = {pte[31:12], lin[11:0]};
            ta0 = ta;
         end
      end
      // a write through a clean cached entry walks again to mark the page dirty
      xlate(lin0, 1, 0, 0, 3'h2, ph0);
      check("dirty_rewalk", mem.m[ta0] & 32'h40, 32'h40);
      // a new base must drop cached translations
      ctl(1, 32'h0002_0000);
      xlate(lin0, 0, 0, 1, 3'h0, 0);
      ctl(1, base);
      xlate(lin0, 0, 0, 0, 3'h0, ph0);
      @(posedge clk) #1;
      tload = 1;
      task_base = 32'h0002_0000;
      @(posedge clk) #1;
      tload = 0;
      check("task_base", dbase, 32'h0002_0000);
      xlate(lin0, 0, 0, 1, 3'h0, 0);
      test_done();
   end
endmodule
`default_nettype wire
